/* File: rtl/ustf_framer.sv */
// udp stream transfer header framer: wraps recorder packets into datagram payloads
`timescale 1ns/1ps
`default_nettype none
module ustf_framer #(
    parameter int DGRAM_WORDS = ustf_pkg::DGRAM_WORDS_DEF
) (
    input  wire logic                             clk,
    input  wire logic                             rst,
    input  wire logic                             stream_start_command,
    input  wire logic                             in_valid,
    output logic                                  in_ready,
    input  wire logic [ustf_pkg::DATA_W-1:0]      in_data,
    input  wire logic                             in_sop,
    input  wire logic                             in_eop,
    input  wire logic [ustf_pkg::PKT_WORDS_W-1:0] in_pkt_words,
    input  wire logic [ustf_pkg::CHAN_ID_W-1:0]   in_chan_id,
    input  wire logic [ustf_pkg::CHAN_SEQ_W-1:0]  in_chan_seq,
    output logic                                  out_valid,
    input  wire logic                             out_ready,
    output logic [ustf_pkg::DATA_W-1:0]           out_data,
    output logic                                  out_sod,
    output logic                                  out_eod
);
    import ustf_pkg::*;

    localparam int SEG_WORDS = DGRAM_WORDS - SEG_HDR_WORDS;
    localparam int SEG_CNT_W = $clog2(DGRAM_WORDS + 1);
    localparam logic [PKT_WORDS_W-1:0] FULL_MAX = PKT_WORDS_W'(DGRAM_WORDS - 1);
    localparam logic [SEG_CNT_W-1:0]   SEG_LAST = SEG_CNT_W'(SEG_WORDS - 1);
    localparam int OFF_PAD = DATA_W - PKT_WORDS_W - 2;

    ustf_state_t              state_reg;
    ustf_state_t              state_next;
    logic [SEQ_W-1:0]         seq_reg;
    logic                     seg_mode_reg;
    logic [CHAN_ID_W-1:0]     chan_id_reg;
    logic [CHAN_SEQ_W-1:0]    chan_seq_reg;
    logic [PKT_WORDS_W-1:0]   word_off_reg;
    logic [SEG_CNT_W-1:0]     seg_cnt_reg;
    logic                     in_ready_reg;
    logic                     push;
    logic [BUF_W-1:0]         push_word;
    logic                     last_data;
    logic                     take;
    logic                     pkt_start;
    logic [BUF_W-1:0]         out_word;

    ustf_buf_if #(.W(BUF_W)) bif ();

    ////////////////////////////////////////////////////////////////////////
    // sequencing of header and data words
    assign take      = (state_reg == ST_DATA) && in_valid && in_ready_reg;
    assign pkt_start = (state_reg == ST_IDLE) && (state_next == ST_HDR0);

    always_comb begin
        state_next = state_reg;
        push       = 1'b0;
        push_word  = '0;
        last_data  = 1'b0;
        unique case (state_reg)
            ST_IDLE: begin
                // gate only at a packet boundary so no packet is cut short
                if (in_valid && in_sop && stream_start_command) begin
                    state_next = ST_HDR0;
                end
            end
            ST_HDR0: begin
                push_word[SOD_BIT]                  = 1'b1;
                push_word[SEQ_LSB +: SEQ_W]         = seq_reg;
                push_word[TYPE_LSB +: 4]            = seg_mode_reg ? TYPE_SEG : TYPE_FULL;
                push_word[VER_LSB +: 4]             = VERSION_ONE;
                if (bif.room) begin
                    push       = 1'b1;
                    state_next = seg_mode_reg ? ST_HDR1 : ST_DATA;
                end
            end
            ST_HDR1: begin
                push_word[RSVD_LSB +: RSVD_W]         = RSVD_VALUE;
                push_word[CHAN_SEQ_LSB +: CHAN_SEQ_W] = chan_seq_reg;
                push_word[CHAN_ID_LSB +: CHAN_ID_W]   = chan_id_reg;
                if (bif.room) begin
                    push       = 1'b1;
                    state_next = ST_HDR2;
                end
            end
            ST_HDR2: begin
                // byte position of the first data word of this segment
                push_word[DATA_W-1:0] = {{OFF_PAD{1'b0}}, word_off_reg, 2'b00};
                if (bif.room) begin
                    push       = 1'b1;
                    state_next = ST_DATA;
                end
            end
            ST_DATA: begin
                last_data             = in_eop || (seg_mode_reg && seg_cnt_reg == SEG_LAST);
                push_word[DATA_W-1:0] = in_data;
                push_word[EOD_BIT]    = last_data;
                if (take) begin
                    push       = 1'b1;
                    state_next = in_eop ? ST_IDLE : (last_data ? ST_HDR0 : ST_DATA);
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ready is registered; room_next guarantees the buffer can take the word
    always_ff @(posedge clk) begin
        if (rst) begin
            in_ready_reg <= 1'b0;
        end else begin
            in_ready_reg <= (state_next == ST_DATA) && bif.room_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-packet context, latched before the first word is accepted
    always_ff @(posedge clk) begin
        if (rst) begin
            seg_mode_reg <= 1'b0;
            chan_id_reg  <= '0;
            chan_seq_reg <= '0;
        end else if (pkt_start) begin
            seg_mode_reg <= (in_pkt_words > FULL_MAX);
            chan_id_reg  <= in_chan_id;
            chan_seq_reg <= in_chan_seq;
        end
    end

    // message sequence: one step per datagram, free wrap at all ones
    always_ff @(posedge clk) begin
        if (rst) begin
            seq_reg <= SEQ_RESET;
        end else if (push && state_reg == ST_HDR0) begin
            seq_reg <= seq_reg + SEQ_W'(1);
        end
    end

    // word position in the packet and word count in the current datagram
    always_ff @(posedge clk) begin
        if (rst) begin
            word_off_reg <= '0;
            seg_cnt_reg  <= '0;
        end else begin
            if (pkt_start) begin
                word_off_reg <= '0;
            end else if (take) begin
                word_off_reg <= word_off_reg + PKT_WORDS_W'(1);
            end
            if (push && state_reg == ST_HDR0) begin
                seg_cnt_reg <= '0;
            end else if (take) begin
                seg_cnt_reg <= seg_cnt_reg + SEG_CNT_W'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output buffer absorbs a receiver stall without losing a word
    assign bif.push      = push;
    assign bif.push_word = push_word;

    ustf_skid_buf #(.W(BUF_W)) u_buf (
        .clk       (clk),
        .rst       (rst),
        .bif       (bif),
        .out_ready (out_ready),
        .out_valid (out_valid),
        .out_word  (out_word)
    );

    assign in_ready = in_ready_reg;
    assign out_data = out_word[DATA_W-1:0];
    assign out_sod  = out_word[SOD_BIT];
    assign out_eod  = out_word[EOD_BIT];

    ////////////////////////////////////////////////////////////////////////
    // checks on header content and datagram shape
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    wire hdr0_push = push && (state_reg == ST_HDR0);

    hdr_version_a: assert property (hdr0_push |-> push_word[3:0] == 4'h1)
        else $error("header version is not one");
    hdr_fields_a: assert property (hdr0_push |-> push_word[31:8] == seq_reg && push_word[SOD_BIT])
        else $error("header word 0 sequence field wrong");
    full_type_a: assert property (hdr0_push && !seg_mode_reg |-> push_word[7:4] == 4'h0 ##1 state_reg == ST_DATA)
        else $error("whole packet datagram header wrong");
    seg_type_a: assert property (hdr0_push && seg_mode_reg |-> push_word[7:4] == 4'h1 ##1 state_reg == ST_HDR1)
        else $error("segment datagram header wrong");
    chan_word_a: assert property (push && state_reg == ST_HDR1 |-> push_word[31:0] == {8'h00, chan_seq_reg, chan_id_reg})
        else $error("channel word wrong");
    seg_offset_a: assert property (push && state_reg == ST_HDR2 |-> push_word[31:0] == {4'h0, word_off_reg, 2'b00})
        else $error("segment offset wrong");
    offset_rise_a: assert property (take |=> word_off_reg == $past(word_off_reg) + 26'd1)
        else $error("segment offset not rising");
    seq_step_a: assert property (hdr0_push |=> seq_reg == $past(seq_reg) + 24'd1)
        else $error("sequence did not step by one");
    seq_reset_a: assert property ($past(rst) |-> seq_reg == 24'h0)
        else $error("sequence not zero after reset");
    seg_len_a: assert property (state_reg == ST_DATA |-> seg_cnt_reg <= SEG_LAST || !seg_mode_reg)
        else $error("segment longer than a datagram allows");
    whole_pkt_a: assert property (take && !seg_mode_reg |-> push_word[EOD_BIT] == in_eop)
        else $error("whole packet datagram ends inside a packet");
    data_pass_a: assert property (take |-> push && push_word[31:0] == in_data)
        else $error("data word not passed unchanged");
    start_gate_a: assert property (pkt_start |-> stream_start_command ##1 state_reg == ST_HDR0)
        else $error("streaming began without start command");

    full_dgram_c: cover property (hdr0_push && !seg_mode_reg ##[1:50] take && in_eop);
    seg_dgram_c: cover property (take && seg_mode_reg && seg_cnt_reg == SEG_LAST && !in_eop);
    stall_c: cover property (state_reg == ST_HDR0 && !bif.room);
    seq_wrap_c: cover property (hdr0_push && seq_reg == 24'hffffff);
endmodule // ustf_framer
`default_nettype wire

/* File: shared/ustf_pkg.sv */
// constants, types and behaviour notes for the udp stream transfer header framer
//
// Notes on behaviour
// - datagrams of whole packets get the one-word short header only.
// - datagrams carrying a packet segment get the extended three-word header.
// - word 0 holds version [3:0], message type [7:4], sequence [31:8].
// - word 1 holds channel id, channel sequence, zero reserved byte; word 2 offset.
// - version field is always binary one; other codes never emitted.
// - payload is header then packet data, words passed unchanged in order.
// - packets up to 128 megabytes are split across several datagrams.
// - streaming starts only once the start command has been given.
// - message type is zero for whole packets and one for segments.
// - sequence number increments by one for every datagram sent.
// - segment offset is the byte position in the packet, sent in rising order.
// - whole-packet datagrams hold an integral number of packets, no fragment.
`default_nettype none
package ustf_pkg;
    localparam int          DATA_W          = 32;
    localparam int          SEQ_W           = 24;
    localparam int          CHAN_ID_W       = 16;
    localparam int          CHAN_SEQ_W      = 8;
    localparam int          RSVD_W          = 8;
    localparam int          VER_LSB         = 0;
    localparam int          TYPE_LSB        = 4;
    localparam int          SEQ_LSB         = 8;
    localparam int          CHAN_ID_LSB     = 0;
    localparam int          CHAN_SEQ_LSB    = 16;
    localparam int          RSVD_LSB        = 24;
    localparam logic [3:0]  VERSION_ONE     = 4'h1;
    localparam logic [3:0]  TYPE_FULL       = 4'h0;
    localparam logic [3:0]  TYPE_SEG        = 4'h1;
    localparam logic [7:0]  RSVD_VALUE      = 8'h00;
    localparam logic [23:0] SEQ_RESET       = 24'h000000;
    // largest packet is 2^27 bytes, counted here in 32-bit words
    localparam int          MAX_PKT_LOG2    = 27;
    localparam int          PKT_WORDS_W     = MAX_PKT_LOG2 - 2 + 1;
    // ipv4 payload limit in bytes, and the datagram size in words it allows
    localparam int          DGRAM_BYTES     = 32726;
    localparam int          DGRAM_WORDS_DEF = DGRAM_BYTES / 4;
    localparam int          SEG_HDR_WORDS   = 3;
    // buffer word: data plus start and end of datagram marks
    localparam int          BUF_W           = DATA_W + 2;
    localparam int          SOD_BIT         = DATA_W;
    localparam int          EOD_BIT         = DATA_W + 1;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_HDR0 = 5'b00010,
        ST_HDR1 = 5'b00100,
        ST_HDR2 = 5'b01000,
        ST_DATA = 5'b10000
    } ustf_state_t;
endpackage
`default_nettype wire

/* File: shared/ustf_buf_if.sv */
// write side of the framer's output buffer
`timescale 1ns/1ps
`default_nettype none
interface ustf_buf_if #(parameter int W = 34);
    logic         push;       // one word written this cycle
    logic [W-1:0] push_word;
    logic         room;       // registered: a push this cycle fits
    logic         room_next;  // value room takes at the next edge

    modport writer (output push, output push_word, input room, input room_next);
    modport store  (input push, input push_word, output room, output room_next);
endinterface
`default_nettype wire

/* File: rtl/ustf_skid_buf.sv */
// two-entry output buffer with registered ready and registered head word
`timescale 1ns/1ps
`default_nettype none
module ustf_skid_buf #(
    parameter int W = 34
) (
    input  wire logic         clk,
    input  wire logic         rst,
    ustf_buf_if.store         bif,
    input  wire logic         out_ready,
    output logic              out_valid,
    output logic [W-1:0]      out_word
);
    logic [1:0]   count_reg;
    logic [1:0]   count_next;
    logic [W-1:0] mem_reg [2];
    logic         valid_reg;
    logic         room_reg;
    logic         pop;

    ////////////////////////////////////////////////////////////////////////
    // occupancy; writer only pushes while room is high, so no overflow
    assign pop = valid_reg && out_ready;
    always_comb begin
        count_next = count_reg;
        if (bif.push && !pop) begin
            count_next = count_reg + 2'd1;
        end else if (!bif.push && pop) begin
            count_next = count_reg - 2'd1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            count_reg <= 2'd0;
            valid_reg <= 1'b0;
            room_reg  <= 1'b1;
        end else begin
            count_reg <= count_next;
            valid_reg <= (count_next != 2'd0);
            room_reg  <= (count_next != 2'd2);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // entry 0 is always the head, so the output comes straight from a flop
    always_ff @(posedge clk) begin
        if (rst) begin
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
        end else if (pop) begin
            mem_reg[0] <= (count_reg == 2'd2) ? mem_reg[1] : bif.push_word;
            if (count_reg == 2'd2 && bif.push) begin
                mem_reg[1] <= bif.push_word;
            end
        end else if (bif.push) begin
            if (count_reg == 2'd0) begin
                mem_reg[0] <= bif.push_word;
            end else begin
                mem_reg[1] <= bif.push_word;
            end
        end
    end

    assign bif.room      = room_reg;
    assign bif.room_next = (count_next != 2'd2);
    assign out_valid     = valid_reg;
    assign out_word      = mem_reg[0];
endmodule // ustf_skid_buf
`default_nettype wire

/* File: test/ustf_sink_model.sv */
// network subscriber model: takes framed words, promptly or with long stalls
`timescale 1ns/1ps
`default_nettype none
module ustf_sink_model (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic slow,
    output logic      out_ready
);
    logic [2:0] cnt_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // ready changes only after a falling edge, so it is settled at every rising edge
    // a seven-cycle stall fills the two-entry buffer and pushes back on the source
    always_ff @(negedge clk) begin
        if (rst) begin
            cnt_reg   <= 3'h0;
            out_ready <= 1'b0;
        end else begin
            cnt_reg   <= cnt_reg + 3'h1;
            out_ready <= !slow || (cnt_reg == 3'h7);
        end
    end
endmodule // ustf_sink_model
`default_nettype wire

/* File: test/tb.sv */
// self-checking bench for the udp stream transfer header framer
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ustf_pkg::*;
    localparam int DG  = 8;
    localparam int SEG = DG - SEG_HDR_WORDS;
    logic                   clk          = 1'b0;
    logic                   rst          = 1'b1;
    logic                   start        = 1'b1;
    logic                   in_valid     = 1'b0;
    logic                   in_ready;
    logic [DATA_W-1:0]      in_data      = 32'h0;
    logic                   in_sop       = 1'b0;
    logic                   in_eop       = 1'b0;
    logic [PKT_WORDS_W-1:0] in_pkt_words = '0;
    logic [CHAN_ID_W-1:0]   in_chan_id   = 16'h0;
    logic [CHAN_SEQ_W-1:0]  in_chan_seq  = 8'h0;
    logic                   out_valid;
    logic                   out_ready;
    logic [DATA_W-1:0]      out_data;
    logic                   out_sod;
    logic                   out_eod;
    logic                   slow         = 1'b0;
    logic [BUF_W-1:0]       got_q[$];
    logic [SEQ_W-1:0]       exp_seq      = SEQ_RESET;
    int                     fails        = 0;
    int                     check_count  = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // clock, design and far side
    always #50 clk = ~clk;

    ustf_framer #(.DGRAM_WORDS(DG)) u_ustf_framer (
        .clk(clk), .rst(rst), .stream_start_command(start), .in_valid(in_valid),
        .in_ready(in_ready), .in_data(in_data), .in_sop(in_sop), .in_eop(in_eop),
        .in_pkt_words(in_pkt_words), .in_chan_id(in_chan_id), .in_chan_seq(in_chan_seq),
        .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
        .out_sod(out_sod), .out_eod(out_eod));

    ustf_sink_model u_ustf_sink_model (
        .clk(clk), .rst(rst), .slow(slow), .out_ready(out_ready));

    // every word the sink takes, with its end and start marks on top; the design's
    // outputs are copied at the falling edge where they are settled, so the rising
    // edge pairs them with out_ready without racing the flops that launch them
    logic             held_valid;
    logic [BUF_W-1:0] held_word;
    always @(negedge clk) begin
        held_valid = out_valid;
        held_word = {out_eod, out_sod, out_data};
    end
    always @(posedge clk) begin
        if (held_valid === 1'b1 && out_ready === 1'b1) got_q.push_back(held_word);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // shared tasks
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string name, input logic [BUF_W-1:0] exp, input logic [BUF_W-1:0] got);
        check_count++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            fails++;
        end
    endtask

    task automatic do_reset();
        @(negedge clk);
        rst = 1'b1;
        repeat (5) @(negedge clk);
        chk("out_valid in reset", 34'h0, {33'h0, out_valid});
        chk("in_ready in reset", 34'h0, {33'h0, in_ready});
        rst = 1'b0;
        exp_seq = SEQ_RESET;
        got_q.delete();
    endtask

    // source side: word held until the edge at which in_ready is high
    task automatic send_pkt(input int n, input logic [15:0] id, input logic [7:0] cs, input bit gate);
        int i;
        int t;
        for (i = 0; i < n; i++) begin
            @(negedge clk);
            in_valid = 1'b1;
            in_sop = (i == 0);
            in_eop = (i == n - 1);
            in_data = {cs, 8'h5a, 16'(i)};
            in_pkt_words = PKT_WORDS_W'(n);
            in_chan_id = id;
            in_chan_seq = cs;
            if (gate && i == 0) begin
                start = 1'b0;
                for (t = 0; t < 8; t++) begin
                    @(negedge clk);
                    chk("in_ready before start", 34'h0, {33'h0, in_ready});
                    chk("out_valid before start", 34'h0, {33'h0, out_valid});
                end
                start = 1'b1;
            end
            t = 0;
            while (in_ready !== 1'b1 && t < 200) begin
                @(negedge clk);
                t++;
            end
            if (in_ready !== 1'b1) begin
                fails++;
                conclude();
            end
            @(posedge clk);
        end
        @(negedge clk);
        in_valid = 1'b0;
        in_sop = 1'b0;
        in_eop = 1'b0;
    endtask

    // expected datagrams of one packet, worked out from the framing rules
    task automatic expect_pkt(input int n, input logic [15:0] id, input logic [7:0] cs);
        int nseg;
        int total;
        int k;
        int w;
        int off;
        int len;
        int t;
        bit whole;
        whole = (n <= DG - 1);
        nseg = whole ? 1 : (n + SEG - 1) / SEG;
        total = whole ? n + 1 : n + SEG_HDR_WORDS * nseg;
        t = 0;
        while (got_q.size() < total && t < 2000) begin
            @(negedge clk);
            t++;
        end
        if (got_q.size() < total) begin
            fails++;
            conclude();
        end
        off = 0;
        for (k = 0; k < nseg; k++) begin
            len = whole ? n : ((n - off < SEG) ? n - off : SEG);
            chk("header word0", {2'b01, exp_seq, whole ? TYPE_FULL : TYPE_SEG, VERSION_ONE},
                got_q.pop_front());
            if (!whole) begin
                chk("channel word", {2'b00, RSVD_VALUE, cs, id}, got_q.pop_front());
                chk("offset word", {2'b00, 32'(off * 4)}, got_q.pop_front());
            end
            for (w = 0; w < len; w++) begin
                chk("data word", {w == len - 1, 1'b0, cs, 8'h5a, 16'(off + w)},
                    got_q.pop_front());
            end
            off += len;
            exp_seq++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic scen_gate();
        send_pkt(2, 16'h1234, 8'h01, 1'b1);
        expect_pkt(2, 16'h1234, 8'h01);
    endtask

    // largest whole packet, then the smallest one that must be split
    task automatic scen_boundary();
        send_pkt(DG - 1, 16'h0042, 8'h02, 1'b0);
        send_pkt(DG, 16'h0043, 8'h03, 1'b0);
        expect_pkt(DG - 1, 16'h0042, 8'h02);
        expect_pkt(DG, 16'h0043, 8'h03);
    endtask

    // split packet while the sink stalls, so the buffer fills and refuses
    task automatic scen_stall();
        slow = 1'b1;
        send_pkt(12, 16'hbeef, 8'h7e, 1'b0);
        expect_pkt(12, 16'hbeef, 8'h7e);
        slow = 1'b0;
    endtask

    // a second reset must bring the sequence number back to zero
    task automatic scen_reset();
        do_reset();
        send_pkt(1, 16'h0a0b, 8'hff, 1'b0);
        expect_pkt(1, 16'h0a0b, 8'hff);
    endtask

    initial begin
        do_reset();
        scen_gate();
        scen_boundary();
        scen_stall();
        scen_reset();
        conclude();
    end
endmodule // tb
`default_nettype wire
